// >>> logic/ipm_ctrl.sv
// Interrupt enable, priority, pending flags and chip power-saving control with APB registers.
// Assumes the core acknowledges the presented vector and that sleep sequencing is done by software.
//
// Contract
// RL1: Primary enables per source, gated globally
// RL2: Bit 7 global gate blocks all requests
// RL3: Primary priority bits select high level
// RL4: Extended enable bits for seven sources
// RL5: Extended priority bits mirror extended enables
// RL6: Equal level: lower interrupt number first
// RL7: Extended flags set on source trigger
// RL8: Sleep timer pending flag at bit three
// RL9: Request needs flag, enable and gate
// RL10: Save mode select, entered by start bit
// RL11: Wake sources differ per sleep mode
// RL12: Regulator and oscillator states per mode
// RL13: Sleep timer wake holds core for settling
// RL14: Software programs settle delay at least 0x11
// RL15: Reset wake returns after about 1001 us
// RL16: Halt bit set right after start bit
// RL17: Halt bit stops all core clocks
// RL18: Leaving halt runs the waking handler first
// RL19: Idle bit stops core, cleared by interrupt
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module ipm_ctrl
  import ipm_pkg::*;
#(
  parameter int RESET_WAKE_CYCLES = RESET_WAKE_CYC
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NSRC-1:0]   src_pending,
  input  wire logic              tmr3_trig,
  input  wire logic              aes_trig,
  input  wire logic              tmr2_trig,
  input  wire logic              radio_trig,
  input  wire logic              sleep_tmr_trig,
  input  wire logic              ext_wake,
  input  wire logic              hw_reset_wake,
  input  wire logic              int_ack,
  output logic                   int_req,
  output logic [3:0]             int_num,
  output logic                   core_clk_stop,
  output logic                   core_clk_idle,
  output logic                   analog_regulator,
  output logic                   digital_regulator,
  output logic                   main_osc_on,
  output logic                   sleep_tmr_on,
  output logic                   regs_lost
);
  import ipm_pkg::*;

  // Software-visible registers and the internal wait counter
  logic [7:0]  primary_int_on_reg;  // Global gate and primary enables
  logic [7:0]  primary_prio_reg;    // Primary priorities
  logic [7:0]  ext_int_on_reg;      // Extended enables
  logic [7:0]  ext_prio_reg;        // Extended priorities
  logic [7:0]  ext_flag_reg;        // Extended pending flags
  logic [7:0]  sleep_flag_reg;      // Sleep timer pending flag
  logic [7:0]  core_power_ctrl;     // Halt and idle bits
  logic [1:0]  save_mode_sel_reg;   // Selected save mode
  logic [7:0]  wake_settle_delay;   // Settling delay in microseconds
  ipm_pwr_e    pwr_reg;             // Power sequencer state
  logic [1:0]  active_mode_reg;     // Mode armed by the start bit
  logic [31:0] wait_cnt_reg;        // Settling or reset-wake count

  // Bus decode
  logic        wr_en;               // Write takes effect this edge
  logic        rd_en;               // Read access phase; prdata was loaded at the setup edge
  logic [7:0]  idx;                 // Register index
  logic        mapped;              // Index hits a register
  logic [7:0]  rd_val;              // Read mux
  logic [7:0]  wbyte;               // Low write byte

  // Interrupt vectors by fixed number
  logic [NSRC-1:0] flag_vec;        // Pending per number
  logic [NSRC-1:0] on_vec;          // Enable per number
  logic [NSRC-1:0] hi_vec;          // Priority per number
  logic [NSRC-1:0] qual;            // Qualified requests
  logic            arb_any;         // Any qualified
  logic [3:0]      arb_num;         // Winner number
  logic            wake_evt;        // A wake source hit while asleep
  logic            halt_wake;       // Enabled interrupt ends halt/idle

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign idx   = paddr[ADDR_W-1:2];
  assign wbyte = pwdata[7:0];

  // Read mux; reserved bits read zero
  always_comb begin
    mapped = 1'b1;
    case (idx)
      IDX_PRIMARY_INT_ON:  rd_val = primary_int_on_reg;
      IDX_PRIMARY_PRIO:    rd_val = primary_prio_reg;
      IDX_EXT_INT_ON:      rd_val = ext_int_on_reg;
      IDX_EXT_PRIO:        rd_val = ext_prio_reg;
      IDX_EXT_FLAG:        rd_val = ext_flag_reg;
      IDX_SLEEP_FLAG:      rd_val = sleep_flag_reg;
      IDX_CORE_POWER_CTRL: rd_val = core_power_ctrl;
      IDX_SAVE_MODE_CTRL:  rd_val = {6'h00, save_mode_sel_reg};
      IDX_WAKE_SETTLE:     rd_val = wake_settle_delay;
      IDX_STATUS:          rd_val = {2'h0, active_mode_reg, pwr_reg};
      default: begin
        rd_val = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // APB answer: zero wait states, error on unmapped index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        prdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // Bus valid at the access edge with pready high
  logic acc;
  assign acc = pready;

  // Enable and priority registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_int_on_reg <= REG_RESET;
      primary_prio_reg   <= REG_RESET;
      ext_int_on_reg     <= REG_RESET;
      ext_prio_reg       <= REG_RESET;
    end else if (wr_en && acc) begin
      case (idx)
        IDX_PRIMARY_INT_ON: primary_int_on_reg <= wbyte & PRIMARY_MASK;      // RL1 RL2
        IDX_PRIMARY_PRIO:   primary_prio_reg   <= wbyte & PRIMARY_PRIO_MASK; // RL3
        IDX_EXT_INT_ON:     ext_int_on_reg     <= wbyte & EXT_ON_MASK;       // RL4
        IDX_EXT_PRIO:       ext_prio_reg       <= wbyte & EXT_ON_MASK;       // RL5
        default: ;
      endcase
    end
  end

  logic [7:0] ext_flag_next;        // Extended flags after clear and set
  logic       sleep_pend_next;      // Sleep timer flag after clear and set

  // Next flags: software write, then ack of the presented number, then triggers
  // Triggers are applied last so an event in the clearing cycle is never lost
  always_comb begin
    ext_flag_next   = ext_flag_reg;
    sleep_pend_next = sleep_flag_reg[SLEEP_PEND_BIT];
    if (wr_en && acc && idx == IDX_EXT_FLAG) begin
      ext_flag_next = wbyte & EXT_FLAG_MASK;
    end
    if (wr_en && acc && idx == IDX_SLEEP_FLAG) begin
      sleep_pend_next = wbyte[SLEEP_PEND_BIT];
    end
    // The core acknowledges the number it was shown, not a newer winner
    if (int_ack) begin
      case (int_num)
        4'h8: ext_flag_next[4] = 1'b0;
        4'h9: ext_flag_next[5] = 1'b0;
        4'hA: ext_flag_next[6] = 1'b0;
        4'hB: ext_flag_next[7] = 1'b0;
        4'hC: sleep_pend_next = 1'b0;
        default: ;
      endcase
    end
    ext_flag_next   = ext_flag_next | {tmr3_trig, aes_trig, tmr2_trig, radio_trig, 4'h0}; // RL7
    sleep_pend_next = sleep_pend_next | sleep_tmr_trig;                                   // RL8
  end

  // Pending flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_flag_reg   <= REG_RESET;
      sleep_flag_reg <= REG_RESET;
    end else begin
      ext_flag_reg   <= ext_flag_next;
      sleep_flag_reg <= {4'h0, sleep_pend_next, 3'h0};
    end
  end

  // Map flags, enables and priorities onto fixed numbers (5 and 6 unused)
  always_comb begin
    flag_vec = {src_pending[14:13], sleep_flag_reg[SLEEP_PEND_BIT], ext_flag_reg[7:4],
                src_pending[7], 2'b00, src_pending[4:0]};
    on_vec   = {ext_int_on_reg[6:5], ext_int_on_reg[4], ext_int_on_reg[3], ext_int_on_reg[2],
                ext_int_on_reg[1], ext_int_on_reg[0], primary_int_on_reg[6], 2'b00,
                primary_int_on_reg[4:0]};
    hi_vec   = {ext_prio_reg[6:5], ext_prio_reg[4], ext_prio_reg[3], ext_prio_reg[2],
                ext_prio_reg[1], ext_prio_reg[0], primary_prio_reg[6], 2'b00,
                primary_prio_reg[4:0]};
    qual     = flag_vec & on_vec & {NSRC{primary_int_on_reg[GLOBAL_GATE_BIT]}}; // RL9 RL1 RL2
  end

  ipm_arbiter i_ipm_arbiter (
    .req     (qual),
    .prio_hi (hi_vec),
    .any     (arb_any),
    .num     (arb_num)
  );

  // Request to core, held off whenever the sequencer is not in run (armed, sleep or settle)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_req <= 1'b0;
      int_num <= 4'h0;
    end else begin
      int_req <= arb_any & (pwr_reg == IPM_RUN);  // RL13
      int_num <= arb_num;                         // RL6
    end
  end

  // Interrupt that ends core halt or idle; the handler then runs before the next instruction
  assign halt_wake = arb_any;

  // Core halt and idle bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_power_ctrl <= REG_RESET;
    end else if (wr_en && acc && idx == IDX_CORE_POWER_CTRL) begin
      core_power_ctrl <= {6'h00, wbyte[HALT_BIT], wbyte[IDLE_BIT]}; // RL17 RL19
    end else if (halt_wake && pwr_reg == IPM_RUN) begin
      core_power_ctrl <= REG_RESET; // RL18 RL19
    end
  end

  // Save mode select and settling delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_mode_sel_reg <= MODE_RUN;
      wake_settle_delay <= WAKE_SETTLE_RESET;
    end else if (wr_en && acc) begin
      if (idx == IDX_SAVE_MODE_CTRL) begin
        save_mode_sel_reg <= wbyte[1:0]; // RL10
      end
      if (idx == IDX_WAKE_SETTLE) begin
        wake_settle_delay <= wbyte; // RL14
      end
    end
  end

  // Wake qualification per mode
  always_comb begin
    wake_evt = ext_wake | ((active_mode_reg != MODE_OFF) & sleep_tmr_trig); // RL11
  end

  // Power sequencer: armed by start bit, sleeps once halt is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg         <= IPM_RUN;
      active_mode_reg <= MODE_RUN;
      wait_cnt_reg    <= 32'h0000_0000;
    end else begin
      case (pwr_reg)
        IPM_RUN: begin
          if (wr_en && acc && idx == IDX_SAVE_MODE_CTRL && wbyte[SAVE_GO_BIT]
              && wbyte[1:0] != MODE_RUN) begin
            active_mode_reg <= wbyte[1:0]; // RL10
            pwr_reg         <= IPM_ARMED;
          end
        end
        IPM_ARMED: begin
          // Halt write must follow next; any other write abandons entry, reads do not
          if (wr_en && acc) begin
            pwr_reg <= (idx == IDX_CORE_POWER_CTRL && wbyte[HALT_BIT]) ? IPM_SLEEP : IPM_RUN; // RL16
          end
        end
        IPM_SLEEP: begin
          if (hw_reset_wake) begin
            wait_cnt_reg <= 32'(RESET_WAKE_CYCLES); // RL15
            pwr_reg      <= IPM_SETTLE;
          end else if (wake_evt) begin
            wait_cnt_reg <= 32'(wake_settle_delay) * 32'(SETTLE_UNIT_CYC); // RL13
            pwr_reg      <= IPM_SETTLE;
          end
        end
        IPM_SETTLE: begin
          if (wait_cnt_reg <= 32'h0000_0001) begin
            pwr_reg         <= IPM_RUN;
            active_mode_reg <= MODE_RUN;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 32'h0000_0001;
          end
        end
        default: pwr_reg <= IPM_RUN;
      endcase
    end
  end

  // Supply and clock controls per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_regulator  <= 1'b1;
      digital_regulator <= 1'b1;
      main_osc_on       <= 1'b1;
      sleep_tmr_on      <= 1'b1;
      regs_lost         <= 1'b0;
      core_clk_stop     <= 1'b0;
      core_clk_idle     <= 1'b0;
    end else begin
      // Oscillator restarts during settle so the core resumes on a stable clock
      analog_regulator  <= (pwr_reg != IPM_SLEEP);                                       // RL12
      main_osc_on       <= (pwr_reg != IPM_SLEEP);                                       // RL12
      digital_regulator <= (pwr_reg != IPM_SLEEP) | (active_mode_reg == MODE_LIGHT);     // RL12
      sleep_tmr_on      <= (pwr_reg != IPM_SLEEP) | (active_mode_reg != MODE_OFF);       // RL12
      regs_lost         <= (pwr_reg == IPM_SLEEP) & (active_mode_reg[1]);                // RL12
      core_clk_stop     <= core_power_ctrl[HALT_BIT] | (pwr_reg == IPM_SETTLE);           // RL17 RL13
      core_clk_idle     <= core_power_ctrl[IDLE_BIT];                                    // RL19
    end
  end
endmodule

// >>> logic/ipm_pkg.sv
// Package for the interrupt and power mode controller: register map, field positions, timing.
// Assumes APB with 32-bit data; each register sits in one aligned word.
package ipm_pkg;
  // Printed offsets are not all multiples of four, so they are register indices
  localparam logic [7:0]  IDX_CORE_POWER_CTRL = 8'h87;
  localparam logic [7:0]  IDX_EXT_FLAG        = 8'h91;
  localparam logic [7:0]  IDX_PRIMARY_PRIO    = 8'hB8;
  localparam logic [7:0]  IDX_SLEEP_FLAG      = 8'hD8;
  localparam logic [7:0]  IDX_EXT_INT_ON      = 8'hE8;
  localparam logic [7:0]  IDX_EXT_PRIO        = 8'hF8;
  localparam logic [7:0]  IDX_PRIMARY_INT_ON  = 8'hA8;
  localparam logic [7:0]  IDX_SAVE_MODE_CTRL  = 8'hF1;
  localparam logic [7:0]  IDX_WAKE_SETTLE     = 8'hF4;
  localparam logic [7:0]  IDX_STATUS          = 8'hFC;
  localparam int          ADDR_W              = 10;
  // Field positions
  localparam int          GLOBAL_GATE_BIT     = 7;
  localparam int          HALT_BIT            = 1;
  localparam int          IDLE_BIT            = 0;
  localparam int          SLEEP_PEND_BIT      = 3;
  localparam int          SAVE_GO_BIT         = 2;
  // Writable masks and reset values
  localparam logic [7:0]  PRIMARY_MASK        = 8'hDF;
  localparam logic [7:0]  PRIMARY_PRIO_MASK   = 8'h5F;
  localparam logic [7:0]  EXT_ON_MASK         = 8'h7F;
  localparam logic [7:0]  EXT_FLAG_MASK       = 8'hF0;
  localparam logic [7:0]  REG_RESET           = 8'h00;
  localparam logic [7:0]  WAKE_SETTLE_RESET   = 8'h11;
  // Save modes
  localparam logic [1:0]  MODE_RUN            = 2'h0;
  localparam logic [1:0]  MODE_LIGHT          = 2'h1;
  localparam logic [1:0]  MODE_DEEP           = 2'h2;
  localparam logic [1:0]  MODE_OFF            = 2'h3;
  // Timing: clock 250 MHz, reset wake about 1001 us, settle unit 1 us (chosen)
  localparam int          CLK_MHZ             = 250;
  localparam int          RESET_WAKE_US       = 1001;
  localparam int          RESET_WAKE_CYC      = RESET_WAKE_US * CLK_MHZ;
  localparam int          SETTLE_UNIT_US      = 1;
  localparam int          SETTLE_UNIT_CYC     = SETTLE_UNIT_US * CLK_MHZ;
  localparam int          NSRC                = 15;
  // Power controller states, one-hot
  typedef enum logic [3:0] {
    IPM_RUN    = 4'h1,
    IPM_ARMED  = 4'h2,
    IPM_SLEEP  = 4'h4,
    IPM_SETTLE = 4'h8
  } ipm_pwr_e;
endpackage

// >>> logic/ipm_arbiter.sv
// Picks the request to present to the core from qualified sources.
// Assumes source index equals the fixed interrupt number; lower wins at equal level.
`timescale 1ns/1ns
module ipm_arbiter
  import ipm_pkg::*;
(
  input  wire logic [NSRC-1:0] req,
  input  wire logic [NSRC-1:0] prio_hi,
  output logic                 any,
  output logic [3:0]           num
);
  // Lowest set index of a vector
  function automatic logic [3:0] ipm_first(input logic [NSRC-1:0] v);
    ipm_first = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        ipm_first = 4'(i);
      end
    end
  endfunction

  logic [NSRC-1:0] hi_req; // High-priority subset

  // High level beats low, then the lower number
  always_comb begin
    hi_req = req & prio_hi;
    any    = |req;
    num    = (|hi_req) ? ipm_first(hi_req) : ipm_first(req); // RL9 RL6
  end
endmodule

// >>> bench/ipm_ctrl_props.sv
// Port checker for the interrupt and power mode controller.
// Assumes it is bound to ipm_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module ipm_ctrl_props
  import ipm_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              sleep_tmr_trig,
  input wire logic              ext_wake,
  input wire logic              hw_reset_wake,
  input wire logic              int_req,
  input wire logic              core_clk_stop,
  input wire logic              analog_regulator,
  input wire logic              digital_regulator,
  input wire logic              main_osc_on,
  input wire logic              sleep_tmr_on,
  input wire logic              regs_lost
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Index of a completed read, zero when no read completes
  logic [7:0] rd_idx;
  assign rd_idx = (pready && !pwrite) ? paddr[9:2] : 8'h00;
  property p_ready_one; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("access answer not one cycle");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside access");
  property p_gate_off; rd_idx == IDX_PRIMARY_INT_ON && !prdata[GLOBAL_GATE_BIT] |-> !int_req; endproperty
  a_gate_off: assert property (p_gate_off) else $error("request with global gate clear");
  property p_on_resv; rd_idx == IDX_PRIMARY_INT_ON |-> !prdata[5]; endproperty
  a_on_resv: assert property (p_on_resv) else $error("enable reserved bit set");
  property p_prio_resv; rd_idx == IDX_PRIMARY_PRIO |-> !prdata[7] && !prdata[5]; endproperty
  a_prio_resv: assert property (p_prio_resv) else $error("priority reserved bit set");
  property p_flag_resv; rd_idx == IDX_EXT_FLAG |-> prdata[3:0] == 4'h0; endproperty
  a_flag_resv: assert property (p_flag_resv) else $error("flag reserved bits set");
  property p_sleep_resv; rd_idx == IDX_SLEEP_FLAG |-> (prdata[7:0] & 8'hF7) == 8'h00; endproperty
  a_sleep_resv: assert property (p_sleep_resv) else $error("sleep flag reserved set");
  property p_osc_analog; analog_regulator == main_osc_on; endproperty
  a_osc_analog: assert property (p_osc_analog) else $error("analog and oscillator differ");
  property p_regs_lost; (regs_lost == !digital_regulator) && (sleep_tmr_on || regs_lost); endproperty
  a_regs_lost: assert property (p_regs_lost) else $error("regulator state wrong");
  property p_asleep; !main_osc_on |-> !int_req && core_clk_stop; endproperty
  a_asleep: assert property (p_asleep) else $error("core active while asleep");
  property p_off_no_wake; !sleep_tmr_on && sleep_tmr_trig && !ext_wake && !hw_reset_wake |=> !main_osc_on; endproperty
  a_off_no_wake: assert property (p_off_no_wake) else $error("timer woke off sleep");
  property p_reset_wake; !main_osc_on && hw_reset_wake |-> ##[1:3] main_osc_on; endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("reset wake missed");
endmodule
bind ipm_ctrl ipm_ctrl_props i_ipm_ctrl_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_tmr_trig(sleep_tmr_trig), .ext_wake(ext_wake),
  .hw_reset_wake(hw_reset_wake), .int_req(int_req), .core_clk_stop(core_clk_stop),
  .analog_regulator(analog_regulator), .digital_regulator(digital_regulator),
  .main_osc_on(main_osc_on), .sleep_tmr_on(sleep_tmr_on), .regs_lost(regs_lost));

// >>> bench/ipm_core_model.sv
// Behavioural core: takes a presented request and acknowledges it once.
// Assumes ack_on is driven by the bench; slow widens the gap between acks.
`timescale 1ns/1ns
module ipm_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic int_req,
  input  wire logic ack_on,
  input  wire logic slow,
  output logic      int_ack
);
  logic [2:0] gap_reg; // Cycles left before the next ack
  // One-cycle ack, then a gap so the cleared flag can settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ack <= 1'b0;
      gap_reg <= 3'h0;
    end else begin
      int_ack <= ack_on && int_req && gap_reg == 3'h0 && !int_ack;
      gap_reg <= int_ack ? (slow ? 3'h7 : 3'h3) : gap_reg - 3'(gap_reg != 3'h0);
    end
  end
endmodule

// >>> bench/ipm_ctrl_bench.sv
// Self-checking bench for ipm_ctrl over APB with a core model.
// Assumes a 250 MHz clock and a shortened reset wake of 20 cycles.
`timescale 1ns/1ns
module ipm_ctrl_bench;
  import ipm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, int_req, int_ack, ack_on = 1'b0, core_clk_stop, core_clk_idle;
  logic analog_regulator, digital_regulator, main_osc_on, sleep_tmr_on, regs_lost;
  logic [14:0] src_pending = '0;
  logic [6:0] trig = '0; // tmr3 aes tmr2 radio sleep_tmr ext_wake hw_reset_wake
  logic [3:0] int_num;
  int n_mismatch = 0, checks = 0, cyc = 0;
  logic [7:0] zi [9] = '{IDX_CORE_POWER_CTRL, IDX_EXT_FLAG, IDX_PRIMARY_PRIO, IDX_SLEEP_FLAG,
    IDX_EXT_INT_ON, IDX_EXT_PRIO, IDX_PRIMARY_INT_ON, IDX_SAVE_MODE_CTRL, IDX_WAKE_SETTLE};
  logic [7:0] mi [4] = '{IDX_PRIMARY_INT_ON, IDX_PRIMARY_PRIO, IDX_EXT_INT_ON, IDX_EXT_PRIO};
  logic [7:0] mk [4] = '{PRIMARY_MASK, PRIMARY_PRIO_MASK, EXT_ON_MASK, EXT_ON_MASK};
  ipm_ctrl #(.RESET_WAKE_CYCLES(20)) i_ipm_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_pending(src_pending), .tmr3_trig(trig[0]),
    .aes_trig(trig[1]), .tmr2_trig(trig[2]), .radio_trig(trig[3]), .sleep_tmr_trig(trig[4]),
    .ext_wake(trig[5]), .hw_reset_wake(trig[6]), .int_ack(int_ack), .int_req(int_req),
    .int_num(int_num), .core_clk_stop(core_clk_stop), .core_clk_idle(core_clk_idle),
    .analog_regulator(analog_regulator), .digital_regulator(digital_regulator),
    .main_osc_on(main_osc_on), .sleep_tmr_on(sleep_tmr_on), .regs_lost(regs_lost));
  ipm_core_model i_ipm_core_model (.pclk(pclk), .presetn(presetn), .int_req(int_req),
    .ack_on(ack_on), .slow(cyc[0]), .int_ack(int_ack));
  always #2 pclk = ~pclk;
  // Hang guard: the whole run needs about 9000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdat, exp);
  endtask
  task automatic rds(input logic [3:0] st);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk(32'(rdat[3:0]), 32'(st));
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge pclk);
    trig <= m;
    @(posedge pclk);
    trig <= 7'h00;
  endtask
  task automatic t_regs();
    foreach (zi[i]) rd(zi[i], (i == 8) ? 32'(WAKE_SETTLE_RESET) : 32'(REG_RESET));
    rds(4'h1);
    foreach (mi[i]) begin
      wr(mi[i], 8'hFF);
      rd(mi[i], 32'(mk[i]));
      wr(mi[i], 8'h00);
    end
    apb(1'b1, 8'h10, 8'hFF);
    chk(32'(rerr), 32'h1);
    $display("test regs done");
  endtask
  task automatic t_irq();
    wr(IDX_EXT_INT_ON, 8'h1F);
    pulse(7'h1F);
    tick(3);
    chk(32'(int_req), 32'h0);
    rd(IDX_EXT_FLAG, 32'hF0);
    rd(IDX_SLEEP_FLAG, 32'h08);
    rd(IDX_PRIMARY_INT_ON, 32'h0);
    wr(IDX_PRIMARY_INT_ON, 8'h80);
    tick(3);
    chk(32'({int_req, int_num}), 32'h18);
    wr(IDX_EXT_PRIO, 8'h08);
    tick(3);
    chk(32'(int_num), 32'hB);
    ack_on <= 1'b1;
    tick(40);
    ack_on <= 1'b0;
    rd(IDX_EXT_FLAG, 32'h0);
    chk(32'(int_req), 32'h0);
    wr(IDX_EXT_PRIO, 8'h00);
    wr(IDX_PRIMARY_INT_ON, 8'h83);
    wr(IDX_PRIMARY_PRIO, 8'h02);
    src_pending <= 15'h0003;
    tick(3);
    chk(32'(int_num), 32'h1);
    wr(IDX_PRIMARY_PRIO, 8'h00);
    tick(3);
    chk(32'(int_num), 32'h0);
    wr(IDX_PRIMARY_INT_ON, 8'h82);
    tick(3);
    chk(32'(int_num), 32'h1);
    src_pending <= 15'h0000;
    wr(IDX_PRIMARY_INT_ON, 8'h80);
    $display("test irq done");
  endtask
  task automatic t_idle();
    wr(IDX_CORE_POWER_CTRL, 8'h01);
    tick(2);
    chk(32'(core_clk_idle), 32'h1);
    pulse(7'h08);
    tick(4);
    chk(32'({core_clk_idle, int_req}), 32'h1);
    ack_on <= 1'b1;
    tick(10);
    ack_on <= 1'b0;
    wr(IDX_SAVE_MODE_CTRL, 8'h05);
    rd(IDX_SAVE_MODE_CTRL, 32'h1);
    rds(4'h2);
    wr(IDX_EXT_PRIO, 8'h00);
    rds(4'h1);
    $display("test idle done");
  endtask
  task automatic t_sleep(input logic [1:0] mode);
    int n;
    n = (mode == MODE_OFF) ? 20 : int'(WAKE_SETTLE_RESET) * SETTLE_UNIT_CYC;
    wr(IDX_SAVE_MODE_CTRL, {6'h01, mode});
    wr(IDX_CORE_POWER_CTRL, 8'h02);
    tick(3);
    chk(32'({analog_regulator, main_osc_on, digital_regulator, regs_lost}), (mode == MODE_LIGHT) ? 32'h2 : 32'h1);
    chk(32'({sleep_tmr_on, core_clk_stop}), {30'h0, mode != MODE_OFF, 1'b1});
    rd(IDX_STATUS, 32'({mode, 4'h4}));
    pulse(mode == MODE_OFF ? 7'h18 : 7'h08);
    tick(4);
    chk(32'(main_osc_on), 32'h0);
    pulse(mode == MODE_LIGHT ? 7'h10 : (mode == MODE_DEEP ? 7'h20 : 7'h40));
    tick(n - 12);
    rds(4'h8);
    chk(32'(core_clk_stop), 32'h1);
    tick(30);
    rds(4'h1);
    if (mode == MODE_LIGHT) chk(32'({core_clk_stop, int_req}), 32'h1);
    ack_on <= 1'b1;
    tick(30);
    ack_on <= 1'b0;
    $display("test sleep mode %0d done", mode);
  endtask
  initial begin
    tick(20);
    presetn <= 1'b1;
    t_regs();
    t_irq();
    t_idle();
    t_sleep(MODE_LIGHT);
    t_sleep(MODE_DEEP);
    t_sleep(MODE_OFF);
    give_verdict();
  end
endmodule
